// [hw/sbtc_pkg.sv]
package sbtc_pkg;

  // ****************************************************************
  // Register indices; the byte address is four times the index.
  // ****************************************************************
  localparam logic [7:0] IDX_BALANCE_GAIN  = 8'h28;
  localparam logic [7:0] IDX_SHARE_BW      = 8'h29;
  localparam logic [7:0] IDX_SHARE_SETTING = 8'h2A;
  localparam logic [7:0] IDX_TEMP_TRIM     = 8'h2B;
  localparam int         NUM_REGS          = 4;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [7:0] RST_BALANCE_GAIN  = 8'h00;
  localparam logic [7:0] RST_SHARE_BW      = 8'h00;
  localparam logic [7:0] RST_SHARE_SETTING = 8'h00;
  localparam logic [7:0] RST_TEMP_TRIM     = 8'h00;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int BAL_GAIN_LSB  = 0;
  localparam int BAL_GAIN_W    = 2;
  localparam int BW_LSB        = 0;
  localparam int BW_W          = 3;
  localparam int SRC_BIT       = 3;
  localparam int STREAM_BIT    = 4;
  localparam int WINDOW_LSB    = 0;
  localparam int DROP_LSB      = 4;
  localparam int NIBBLE_W      = 4;
  localparam int TRIM_LSB      = 0;
  localparam int POL_BIT       = 4;

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int CLK_PERIOD_NS      = 100;
  localparam int BAL_SETTLE_SLOW_MS = 700;
  localparam int BAL_SETTLE_FAST_MS = 10;
  localparam int BAL_UPDATE_NS      = 100000;
  localparam int BAL_CYCLES         = BAL_UPDATE_NS / CLK_PERIOD_NS;
  // Integrator time constant is about 2**BAL_FRAC updates at gain 1.
  localparam int BAL_FRAC           = 13;
  localparam int SHARE_BASE_NS      = 1000;
  localparam int SHARE_BASE_CYCLES  = SHARE_BASE_NS / CLK_PERIOD_NS;
  localparam int TRIM_SHIFT         = 7;

  typedef struct packed {
    logic [1:0] bal_gain;
    logic       stream_sel;
    logic       src_primary;
    logic [2:0] bandwidth;
    logic [3:0] drop;
    logic [3:0] window;
    logic       trim_negative;
    logic [3:0] trim;
  } sbtc_cfg_t;

endpackage : sbtc_pkg

// [hw/sbtc_stream_mod.sv]
`timescale 1ns/1ns
module sbtc_stream_mod #(
  parameter int W = 12
) (
  input  wire logic         pclk,      // System clock.
  input  wire logic         presetn,   // Asynchronous reset, active low.
  input  wire logic         enable,    // Modulator runs while high.
  input  wire logic [W-1:0] value,     // Level to be coded as ones density.
  output logic              bit_out    // Registered bit stream.
);

  // ****************************************************************
  // First-order accumulator; the carry is the stream bit.
  // ****************************************************************
  logic [W-1:0] acc;
  logic [W-1:0] next_acc;
  logic         next_bit;
  logic [W:0]   sum;

  always_comb begin
    sum      = {1'b0, acc} + {1'b0, value};
    next_acc = acc;
    next_bit = 1'b0;
    if (enable) begin
      next_acc = sum[W-1:0];
      next_bit = sum[W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc     <= '0;
      bit_out <= 1'b0;
    end else begin
      acc     <= next_acc;
      bit_out <= next_bit;
    end
  end

endmodule : sbtc_stream_mod

// [hw/sbtc_top.sv]
`timescale 1ns/1ns
module sbtc_top #(
  parameter int ADC_W  = 12,
  parameter int ADDR_W = 8
) (
  input  wire logic                    pclk,                     // 10 MHz clock.
  input  wire logic                    presetn,                  // Async reset, low.
  input  wire logic                    psel,                     // APB select.
  input  wire logic                    penable,                  // APB access phase.
  input  wire logic                    pwrite,                   // APB write.
  input  wire logic [ADDR_W-1:0]       paddr,                    // APB byte address.
  input  wire logic [31:0]             pwdata,                   // APB write data.
  input  wire logic [3:0]              pstrb,                    // APB byte strobes.
  output logic      [31:0]             prdata,                   // APB read data.
  output logic                         pready,                   // APB ready.
  output logic                         pslverr,                  // APB error.
  input  wire logic [ADC_W-1:0]        primary_current_sense,    // Primary current.
  input  wire logic [ADC_W-1:0]        secondary_current_sense,  // Secondary current.
  input  wire logic [ADC_W-1:0]        temperature_sense_input,  // Raw temperature.
  input  wire logic                    share_digital_tx,         // Digital share bit.
  input  wire logic [ADC_W-1:0]        share_bus_level,          // Level on share bus.
  input  wire logic                    share_master,             // Acting as master.
  input  wire logic                    vs_balance_enable,        // Balance loop on.
  input  wire logic signed [ADC_W-1:0] balance_error,            // Branch imbalance.
  output logic                         share_output_pin,         // Share pin drive.
  output logic      [ADC_W-1:0]        share_current,            // Share measurement.
  output logic                         share_tick,               // Share update pulse.
  output logic                         share_matched,            // Slave matched.
  output logic signed [7:0]            share_trim,               // Voltage trim, LSBs.
  output logic signed [ADC_W+1:0]      bridge_output_b_adjust,   // Extra modulation B.
  output logic signed [ADC_W+1:0]      bridge_output_d_adjust,   // Extra modulation D.
  output logic      [ADC_W-1:0]        temperature_corrected     // Trimmed temperature.
);

  localparam int ACC_W = ADC_W + 2 + sbtc_pkg::BAL_FRAC;
  localparam logic signed [ACC_W-1:0] ACC_MAX = {1'b0, {(ACC_W-1){1'b1}}};
  localparam logic signed [ACC_W-1:0] ACC_MIN = -ACC_MAX;
  localparam logic [10:0] BAL_RELOAD = 11'(sbtc_pkg::BAL_CYCLES - 1);

  // ****************************************************************
  // Register decode.
  // ****************************************************************
  function automatic logic [2:0] reg_hit(input logic [ADDR_W-1:0] addr);
    logic [2:0] r;
    r = 3'h0;
    if (addr[1:0] != 2'h0) begin
      r = 3'h0;
    end else if (addr[ADDR_W-1:2] == (ADDR_W-2)'(sbtc_pkg::IDX_BALANCE_GAIN)) begin
      r = 3'h4;
    end else if (addr[ADDR_W-1:2] == (ADDR_W-2)'(sbtc_pkg::IDX_SHARE_BW)) begin
      r = 3'h5;
    end else if (addr[ADDR_W-1:2] == (ADDR_W-2)'(sbtc_pkg::IDX_SHARE_SETTING)) begin
      r = 3'h6;
    end else if (addr[ADDR_W-1:2] == (ADDR_W-2)'(sbtc_pkg::IDX_TEMP_TRIM)) begin
      r = 3'h7;
    end
    return r;
  endfunction : reg_hit

  localparam logic [7:0] RST_VAL [sbtc_pkg::NUM_REGS] = '{
    sbtc_pkg::RST_BALANCE_GAIN, sbtc_pkg::RST_SHARE_BW,
    sbtc_pkg::RST_SHARE_SETTING, sbtc_pkg::RST_TEMP_TRIM};

  logic [2:0]  hit;
  logic        wr_en;
  logic [7:0]  regs     [sbtc_pkg::NUM_REGS];
  logic [7:0]  next_regs[sbtc_pkg::NUM_REGS];
  logic [31:0] next_prdata;

  assign hit     = reg_hit(paddr);
  // Reads are sampled in the setup cycle, so the access cycle never waits.
  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~hit[2];
  assign wr_en   = psel & penable & pwrite & hit[2] & pstrb[0];

  // ****************************************************************
  // Register bank.
  // ****************************************************************
  for (genvar i = 0; i < sbtc_pkg::NUM_REGS; i++) begin : g_reg
    always_comb begin
      next_regs[i] = regs[i];
      if (wr_en && hit[1:0] == 2'(i)) begin
        next_regs[i] = pwdata[7:0];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        regs[i] <= RST_VAL[i];
      end else begin
        regs[i] <= next_regs[i];
      end
    end
  end

  always_comb begin
    next_prdata = prdata;
    if (psel && !penable && !pwrite) begin
      next_prdata = 32'h0000_0000;
      if (reg_hit(paddr) != 3'h0) begin
        next_prdata = {24'h00_0000, regs[hit[1:0]]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

  sbtc_pkg::sbtc_cfg_t cfg;

  always_comb begin
    cfg.bal_gain      = regs[0][sbtc_pkg::BAL_GAIN_LSB +: sbtc_pkg::BAL_GAIN_W];
    cfg.stream_sel    = regs[1][sbtc_pkg::STREAM_BIT];
    cfg.src_primary   = regs[1][sbtc_pkg::SRC_BIT];
    cfg.bandwidth     = regs[1][sbtc_pkg::BW_LSB +: sbtc_pkg::BW_W];
    cfg.drop          = regs[2][sbtc_pkg::DROP_LSB +: sbtc_pkg::NIBBLE_W];
    cfg.window        = regs[2][sbtc_pkg::WINDOW_LSB +: sbtc_pkg::NIBBLE_W];
    cfg.trim_negative = regs[3][sbtc_pkg::POL_BIT];
    cfg.trim          = regs[3][sbtc_pkg::TRIM_LSB +: sbtc_pkg::NIBBLE_W];
  end

  // ****************************************************************
  // Volt-second balance integrator.
  // ****************************************************************
  // Each gain step is a shift of two, so the settle time drops by four per step.
  logic [10:0]             bal_cnt;
  logic [10:0]             next_bal_cnt;
  logic                    bal_tick;
  logic signed [ACC_W-1:0] bal_acc;
  logic signed [ACC_W-1:0] next_bal_acc;
  logic signed [ACC_W-1:0] bal_step;
  logic signed [ACC_W:0]   bal_sum;
  logic                    bal_sat;

  assign bal_tick = (bal_cnt == 11'h000);

  always_comb begin
    next_bal_cnt = bal_tick ? BAL_RELOAD : bal_cnt - 11'h001;
    bal_step     = ACC_W'(balance_error) <<< {cfg.bal_gain, 1'b0};
    bal_sum      = {bal_acc[ACC_W-1], bal_acc} + {bal_step[ACC_W-1], bal_step};
    bal_sat      = bal_sum[ACC_W] != bal_sum[ACC_W-1];
    next_bal_acc = bal_acc;
    if (!vs_balance_enable) begin
      next_bal_acc = '0;
    end else if (bal_tick) begin
      if (bal_sat) begin
        next_bal_acc = bal_sum[ACC_W] ? ACC_MIN : ACC_MAX;
      end else begin
        next_bal_acc = bal_sum[ACC_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bal_cnt                <= BAL_RELOAD;
      bal_acc                <= '0;
      bridge_output_b_adjust <= '0;
      bridge_output_d_adjust <= '0;
    end else begin
      bal_cnt                <= next_bal_cnt;
      bal_acc                <= next_bal_acc;
      bridge_output_b_adjust <= bal_acc[ACC_W-1:sbtc_pkg::BAL_FRAC];
      bridge_output_d_adjust <= -bal_acc[ACC_W-1:sbtc_pkg::BAL_FRAC];
    end
  end

  // ****************************************************************
  // Current share.
  // ****************************************************************
  logic [10:0]         sh_cnt;
  logic [10:0]         next_sh_cnt;
  logic [10:0]         sh_period;
  logic [ADC_W-1:0]    next_share_current;
  logic signed [ADC_W:0] sh_diff;
  logic [ADC_W:0]      sh_abs;
  logic                next_share_matched;
  logic signed [7:0]   next_share_trim;
  logic                next_share_pin;
  logic                stream_bit;

  assign share_tick = (sh_cnt == 11'h000);

  always_comb begin
    sh_period   = 11'(sbtc_pkg::SHARE_BASE_CYCLES) << (3'h7 - cfg.bandwidth);
    next_sh_cnt = share_tick ? sh_period - 11'h001 : sh_cnt - 11'h001;
    next_share_current = cfg.src_primary ? primary_current_sense
                                         : secondary_current_sense;
    sh_diff = $signed({1'b0, share_bus_level}) - $signed({1'b0, share_current});
    sh_abs  = sh_diff[ADC_W] ? (ADC_W+1)'(-sh_diff) : sh_diff;
    next_share_matched = sh_abs <= (ADC_W+1)'(cfg.window);
    next_share_trim    = share_trim;
    if (share_master) begin
      next_share_trim = -$signed({4'h0, cfg.drop});
    end else if (share_tick && !next_share_matched) begin
      if (!sh_diff[ADC_W] && share_trim != 8'sh7F) begin
        next_share_trim = share_trim + 8'sh01;
      end else if (sh_diff[ADC_W] && share_trim != -8'sh7F) begin
        next_share_trim = share_trim - 8'sh01;
      end
    end
    next_share_pin = cfg.stream_sel ? stream_bit : share_digital_tx;
  end

  sbtc_stream_mod #(.W(ADC_W)) u_stream (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (cfg.stream_sel),
    .value   (share_current),
    .bit_out (stream_bit)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_cnt           <= '0;
      share_current    <= '0;
      share_matched    <= 1'b0;
      share_trim       <= '0;
      share_output_pin <= 1'b0;
    end else begin
      sh_cnt           <= next_sh_cnt;
      share_current    <= next_share_current;
      share_matched    <= next_share_matched;
      share_trim       <= next_share_trim;
      share_output_pin <= next_share_pin;
    end
  end

  // ****************************************************************
  // Temperature gain trim.
  // ****************************************************************
  // Full-scale trim of 15/128 gives roughly twelve percent either way.
  logic [ADC_W+3:0]   t_prod;
  logic [ADC_W-1:0]   t_delta;
  logic [ADC_W:0]     t_sum;
  logic [ADC_W-1:0]   next_temp;

  always_comb begin
    t_prod  = temperature_sense_input * cfg.trim;
    t_delta = ADC_W'(t_prod >> sbtc_pkg::TRIM_SHIFT);
    if (cfg.trim_negative) begin
      t_sum     = {1'b0, temperature_sense_input} - {1'b0, t_delta};
      next_temp = t_sum[ADC_W] ? '0 : t_sum[ADC_W-1:0];
    end else begin
      t_sum     = {1'b0, temperature_sense_input} + {1'b0, t_delta};
      next_temp = t_sum[ADC_W] ? '1 : t_sum[ADC_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temperature_corrected <= '0;
    end else begin
      temperature_corrected <= next_temp;
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  property p_bal_gain;
    @(posedge pclk) disable iff (!presetn)
    bal_tick && vs_balance_enable && !bal_sat |=>
      bal_acc == $past(bal_acc) + $past(bal_step)
      && $past(bal_step) == ($past(ACC_W'(balance_error)) <<< (2 * $past(cfg.bal_gain)));
  endproperty
  a_bal_gain: assert property (p_bal_gain) else $error("balance step gain wrong");

  property p_bal_period;
    @(posedge pclk) disable iff (!presetn)
    bal_tick |=> bal_cnt == BAL_RELOAD ##1 !bal_tick [*8];
  endproperty
  a_bal_period: assert property (p_bal_period) else $error("balance period wrong");

  property p_stream_pin;
    @(posedge pclk) disable iff (!presetn)
    cfg.stream_sel ##1 cfg.stream_sel |-> share_output_pin == $past(stream_bit);
  endproperty
  a_stream_pin: assert property (p_stream_pin) else $error("stream not on pin");

  property p_digital_pin;
    @(posedge pclk) disable iff (!presetn)
    !cfg.stream_sel |=> share_output_pin == $past(share_digital_tx);
  endproperty
  a_digital_pin: assert property (p_digital_pin) else $error("digital share not on pin");

  property p_share_src;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> share_current == ($past(cfg.src_primary) ? $past(primary_current_sense)
                                                      : $past(secondary_current_sense));
  endproperty
  a_share_src: assert property (p_share_src) else $error("share source wrong");

  property p_share_bw;
    @(posedge pclk) disable iff (!presetn)
    share_tick |=> sh_cnt == 11'(($past(sh_period)) - 11'h001);
  endproperty
  a_share_bw: assert property (p_share_bw) else $error("share period wrong");

  property p_master_drop;
    @(posedge pclk) disable iff (!presetn)
    share_master |=> share_trim == -$signed({4'h0, $past(cfg.drop)});
  endproperty
  a_master_drop: assert property (p_master_drop) else $error("master drop wrong");

  property p_slave_hold;
    @(posedge pclk) disable iff (!presetn)
    !share_master && next_share_matched |=> share_trim == $past(share_trim) && share_matched;
  endproperty
  a_slave_hold: assert property (p_slave_hold) else $error("slave moved while matched");

  property p_temp_pol;
    @(posedge pclk) disable iff (!presetn)
    cfg.trim != 4'h0 && temperature_sense_input >= ADC_W'(256) |=>
      ($past(cfg.trim_negative) ? temperature_corrected < $past(temperature_sense_input)
                                : temperature_corrected >= $past(temperature_sense_input));
  endproperty
  a_temp_pol: assert property (p_temp_pol) else $error("trim polarity wrong");

  property p_bridge_opposite;
    @(posedge pclk) disable iff (!presetn)
    bridge_output_b_adjust == -bridge_output_d_adjust;
  endproperty
  a_bridge_opposite: assert property (p_bridge_opposite) else $error("bridge not opposite");

  property p_readback;
    @(posedge pclk) disable iff (!presetn)
    wr_en ##1 !psel ##1 (psel && !penable && !pwrite && paddr == $past(paddr, 2)) |=>
      prdata == {24'h00_0000, $past(pwdata[7:0], 3)};
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");

endmodule : sbtc_top

// [tb/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
  // ************************************************************
  // Stimulus and observed signals.
  // ************************************************************
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [3:0]         pstrb = 4'hF;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic [11:0]        pri = 12'h123;
  logic [11:0]        sec = 12'h456;
  logic [11:0]        temp_raw = 12'h000;
  logic               tx = 1'b0;
  logic [11:0]        bus_lvl = 12'h000;
  logic               master = 1'b0;
  logic               bal_en = 1'b0;
  logic signed [11:0] bal_err = 12'sh000;
  logic               pin;
  logic [11:0]        cur;
  logic               tick;
  logic               matched;
  logic signed [7:0]  trim;
  logic signed [13:0] adj_b;
  logic signed [13:0] adj_d;
  logic [11:0]        temp_out;
  int                 err_count = 0;
  int                 tests_run = 0;

  always #50 pclk = ~pclk;

  sbtc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .primary_current_sense(pri),
    .secondary_current_sense(sec), .temperature_sense_input(temp_raw),
    .share_digital_tx(tx), .share_bus_level(bus_lvl), .share_master(master),
    .vs_balance_enable(bal_en), .balance_error(bal_err), .share_output_pin(pin),
    .share_current(cur), .share_tick(tick), .share_matched(matched), .share_trim(trim),
    .bridge_output_b_adjust(adj_b), .bridge_output_d_adjust(adj_d),
    .temperature_corrected(temp_out));

  // ************************************************************
  // Helpers.
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp_val);
    tests_run++;
    if (seen !== exp_val) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp_val);
    end
  endtask : check

  task automatic print_verdict();
    $display("mismatches %0d, comparisons %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  // Holds the request until pready is seen high, as the bus demands.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      input logic [3:0] st, output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  function automatic logic [7:0] ba(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction : ba

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] d;
    logic        e;
    xfer(1'b1, ba(idx), {24'hFFFFFF, v}, 4'hF, d, e);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] d;
    logic        e;
    xfer(1'b0, ba(idx), 32'h0, 4'h0, d, e);
    check(d, {24'h0, v});
  endtask : rd_chk

  // ************************************************************
  // Test sequence.
  // ************************************************************
  initial begin : main
    logic [7:0]  idx [4];
    logic [7:0]  pat [4];
    logic [31:0] d;
    logic        e;
    int          n;
    logic signed [13:0] b0;
    idx = '{sbtc_pkg::IDX_BALANCE_GAIN, sbtc_pkg::IDX_SHARE_BW,
            sbtc_pkg::IDX_SHARE_SETTING, sbtc_pkg::IDX_TEMP_TRIM};
    pat = '{8'hA5, 8'h5A, 8'hC3, 8'h1E};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) rd_chk(idx[i], 8'h00);
    for (int i = 0; i < 4; i++) wr(idx[i], pat[i]);
    for (int i = 0; i < 4; i++) rd_chk(idx[3 - i], pat[3 - i]);
    // Unmapped, misaligned and strobe-less writes must leave the bank alone.
    xfer(1'b1, 8'hB0, 32'hFF, 4'hF, d, e);
    check({31'h0, e}, 32'h1);
    xfer(1'b0, 8'hB0, 32'h0, 4'h0, d, e);
    check(d, 32'h0);
    xfer(1'b1, ba(idx[0]) | 8'h01, 32'h0, 4'hF, d, e);
    check({31'h0, e}, 32'h1);
    xfer(1'b1, ba(idx[0]), 32'h0, 4'h0, d, e);
    rd_chk(idx[0], 8'hA5);
    wr(sbtc_pkg::IDX_SHARE_BW, 8'h07);
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      tx <= ~i[0];
      #1 check({31'h0, pin}, {31'h0, i[0]});
      @(posedge pclk);
      #1 check({31'h0, pin}, {31'h0, ~i[0]});
    end
    check({20'h0, cur}, {20'h0, sec});
    wr(sbtc_pkg::IDX_SHARE_BW, 8'h0F);
    repeat (2) @(posedge pclk);
    check({20'h0, cur}, {20'h0, pri});
    for (int bw = 0; bw < 8; bw++) begin
      wr(sbtc_pkg::IDX_SHARE_BW, 8'(bw));
      n = 0;
      do begin
        @(posedge pclk);
        #1 n++;
      end while (tick !== 1'b1 && n < 3000);
      n = 0;
      do begin
        @(posedge pclk);
        #1 n++;
      end while (tick !== 1'b1 && n < 3000);
      check(32'(n), 32'(10 << (7 - bw)));
    end
    wr(sbtc_pkg::IDX_SHARE_SETTING, 8'h04);
    sec <= 12'h400;
    for (int i = 0; i < 2; i++) begin
      bus_lvl <= 12'h404 + 12'(i);
      repeat (4) @(posedge pclk);
      check({31'h0, matched}, {31'h0, ~i[0]});
    end
    master <= 1'b1;
    for (int k = 5; k < 16; k += 10) begin
      wr(sbtc_pkg::IDX_SHARE_SETTING, 8'(k << 4));
      repeat (30) @(posedge pclk);
      check(32'(trim), 32'(-k));
    end
    temp_raw <= 12'd1000;
    wr(sbtc_pkg::IDX_TEMP_TRIM, 8'h08);
    repeat (4) @(posedge pclk);
    check({20'h0, temp_out}, 32'd1062);
    wr(sbtc_pkg::IDX_TEMP_TRIM, 8'h18);
    repeat (4) @(posedge pclk);
    check({20'h0, temp_out}, 32'd938);
    for (int k = 0; k < 2; k++) begin
      sec <= 12'h800 >> k;
      wr(sbtc_pkg::IDX_SHARE_BW, 8'h10);
      n = 0;
      repeat (256) begin
        @(posedge pclk);
        #1 n += int'(pin === 1'b1);
      end
      check({31'h0, n >= (128 >> k) - 3 && n <= (128 >> k) + 3}, 32'h1);
      @(posedge pclk);
    end
    // Each gain step is four times the last, so the error shrinks by four per code.
    for (int c = 0; c < 4; c++) begin
      bal_en <= 1'b0;
      bal_err <= 12'(-(2048 >> (2 * c)));
      wr(sbtc_pkg::IDX_BALANCE_GAIN, 8'(c));
      bal_en <= 1'b1;
      repeat (10) @(posedge pclk);
      b0 = adj_b;
      repeat (4000) @(posedge pclk);
      check(32'(adj_b - b0), 32'hFFFFFFFF);
      check(32'(adj_d), 32'(-adj_b));
    end
    print_verdict();
  end : main

  initial begin : watchdog
    repeat (60000) @(posedge pclk);
    err_count++;
    print_verdict();
  end : watchdog
endmodule : tb_top
